/* File: design/i2c_slave_consts.svh */
// Purpose: Named offsets, field positions, reset values and counts of the I2C slave.
// Assumes: Included by its bare name before use.
// Notes: Byte addresses on the register bus, one word per register.
`ifndef I2C_SLAVE_CONSTS_SVH
`define I2C_SLAVE_CONSTS_SVH

// ==========================================================
// Register byte offsets.
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004
`define OFS_ADDR 12'h008
`define OFS_TXDATA 12'h00c
`define OFS_RXDATA 12'h010

// ==========================================================
// Control fields.
`define CTRL_EN 0
`define CTRL_TEN 1
`define CTRL_STRETCH_ENABLE_BIT 2
`define CTRL_REL 3

// ==========================================================
// Status fields.
`define STAT_RXF 0
`define STAT_TXF 1
`define STAT_OVF 2
`define STAT_TENM 3
`define STAT_RDIR 4

// ==========================================================
// Bus, reset, ten-bit prefix and count constants.
`define HTRANS_NONSEQ 2'h2
`define HSIZE_WORD 3'h2
`define ADDR_RESET 10'h000
`define BYTE_RESET 8'h00
`define WORD_ZERO 32'h0000_0000
`define TEN_PREFIX 5'h1e
`define CNT_ZERO 4'h0
`define CNT_LAST_DATA 4'h7
`define CNT_ACK_FALL 4'h8
`define CNT_END_FALL 4'h9

`endif

/* File: design/i2c_slave_pkg.sv */
// Purpose: Types shared by the I2C slave files.
// Assumes: Nothing else is needed to compile it.
// Notes: Constants live in the header; only types are here.
package i2c_slave_pkg;

	// ==========================================================
	// Engine states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ADDR2 = 3'h2,
		ST_RX = 3'h3,
		ST_TX = 3'h4
	} slvState_t;

	// ==========================================================
	// Sampled link levels and their events.
	typedef struct packed {
		logic sclHigh;
		logic sdaLevel;
		logic sclRise;
		logic sclFall;
		logic start;
		logic stop;
	} linkEvt_t;

	// ==========================================================
	// Software control settings.
	typedef struct packed {
		logic en;
		logic tenMode;
		logic stretchEn;
	} ctrl_t;

endpackage

/* File: design/i2c_pin_sync.sv */
// Purpose: Brings the link pins into the clock domain and finds their events.
// Assumes: Pins idle high; reset is already synchronous to clk.
// Notes: Events are single-cycle pulses.
`timescale 1ns/1ps
module i2c_pin_sync (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstSync_b,
	// Raw pins.
	input wire logic sclIn,
	input wire logic sdaIn,
	// Sampled levels and events.
	output i2c_slave_pkg::linkEvt_t link
);
	logic [1:0] pinIn;
	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;

	assign pinIn = {sclIn, sdaIn};

	// ==========================================================
	// Two-stage synchronisers and the previous sample.
	for (genvar i = 0; i < 2; i++)
	begin : g_sync
		always_ff @(posedge clk or negedge rstSync_b)
		begin
			if (!rstSync_b)
			begin
				meta_q[i] <= 1'h1;
				sync_q[i] <= 1'h1;
				prev_q[i] <= 1'h1;
			end
			else
			begin
				meta_q[i] <= pinIn[i];
				sync_q[i] <= meta_q[i];
				prev_q[i] <= sync_q[i];
			end
		end
	end

	// ==========================================================
	// Edge and condition detection.
	assign link.sclHigh = sync_q[1];
	assign link.sdaLevel = sync_q[0];
	assign link.sclRise = sync_q[1] && !prev_q[1];
	assign link.sclFall = !sync_q[1] && prev_q[1];
	assign link.start = sync_q[1] && prev_q[1] && prev_q[0] && !sync_q[0];
	assign link.stop = sync_q[1] && prev_q[1] && !prev_q[0] && sync_q[0];

endmodule

/* File: design/i2c_addr_match.sv */
// Purpose: Compares a received byte with the own address.
// Assumes: byteIn holds the byte as it completes.
// Notes: Purely combinational.
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"
module i2c_addr_match (
	// Inputs.
	input wire logic [7:0] byteIn,
	input wire logic [9:0] ownAddr,
	// Results.
	output logic match7,
	output logic matchHi,
	output logic matchLo
);
	// ==========================================================
	// Address compares.
	assign match7 = byteIn[7:1] == ownAddr[6:0];
	assign matchHi = (byteIn[7:3] == `TEN_PREFIX) && (byteIn[2:1] == ownAddr[9:8]);
	assign matchLo = byteIn == ownAddr[7:0];

endmodule

/* File: design/i2c_slave_clock_stretch.sv */
// Purpose: I2C slave engine with address match, buffers and clock stretching.
// Assumes: AHB-Lite register access; link pins are open drain, driven low when oe is high.
// Notes: Link pins are sampled by clk; the bus clock must be well above the link rate.
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"
module i2c_slave_clock_stretch (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_b,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Link pins.
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Slave event.
	output logic slaveEvent
);
	logic rstMeta_q;
	logic rstSync_b;
	i2c_slave_pkg::linkEvt_t link;
	logic match7;
	logic matchHi;
	logic matchLo;
	logic [11:0] addrQ_q;
	logic wrPend_q;
	logic [31:0] hrdata_q;
	logic [31:0] rdWord;
	i2c_slave_pkg::ctrl_t ctrl_q;
	logic [9:0] ownAddr_q;
	logic clockRelease_q;
	logic rxFull_q;
	logic txFull_q;
	logic overflow_q;
	logic tenMatch_q;
	logic [7:0] rxBuf_q;
	logic [7:0] txHold_q;
	i2c_slave_pkg::slvState_t state_q;
	i2c_slave_pkg::slvState_t nextSt_q;
	i2c_slave_pkg::slvState_t nextNow;
	logic [3:0] bitCnt_q;
	logic [7:0] shiftReg_q;
	logic [7:0] txShift_q;
	logic [7:0] byteIn;
	logic txLoaded_q;
	logic txLast_q;
	logic ackPend_q;
	logic ackDrive_q;
	logic evtPend_q;
	logic readDir_q;
	logic slaveEvent_q;
	logic holdScl_q;
	logic ackNow;
	logic evtNow;
	logic tenSet;
	logic tenClr;
	logic addrPhase;
	logic wrCtrl;
	logic wrStat;
	logic wrAddr;
	logic wrTx;
	logic rdRx;
	logic lastRise;
	logic ackFall;
	logic endFall;
	logic rxStore;
	logic txLoad;
	logic txAutoClr;
	logic rxAutoClr;
	logic swSetRel;
	logic active;

	// ==========================================================
	// Reset release synchroniser.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstMeta_q <= 1'h0;
			rstSync_b <= 1'h0;
		end
		else
		begin
			rstMeta_q <= 1'h1;
			rstSync_b <= rstMeta_q;
		end
	end

	// ==========================================================
	// Pin sampling and address compare.
	i2c_pin_sync u_sync (
		.clk(clk),
		.rstSync_b(rstSync_b),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.link(link)
	);

	assign byteIn = {shiftReg_q[6:0], link.sdaLevel};

	i2c_addr_match u_match (
		.byteIn(byteIn),
		.ownAddr(ownAddr_q),
		.match7(match7),
		.matchHi(matchHi),
		.matchLo(matchLo)
	);

	// ==========================================================
	// Bus decode.
	assign addrPhase = hsel && (htrans == `HTRANS_NONSEQ) && hready;
	assign wrCtrl = wrPend_q && (addrQ_q == `OFS_CTRL);
	assign wrStat = wrPend_q && (addrQ_q == `OFS_STAT);
	assign wrAddr = wrPend_q && (addrQ_q == `OFS_ADDR);
	assign wrTx = wrPend_q && (addrQ_q == `OFS_TXDATA);
	assign rdRx = addrPhase && !hwrite && (haddr[11:0] == `OFS_RXDATA);
	assign swSetRel = wrCtrl && hwdata[`CTRL_REL];
	assign hreadyout = 1'h1;
	assign hresp = 1'h0;
	assign hrdata = hrdata_q;

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			addrQ_q <= 12'h000;
			wrPend_q <= 1'h0;
		end
		else
		begin
			addrQ_q <= haddr[11:0];
			wrPend_q <= addrPhase && hwrite && (hsize == `HSIZE_WORD);
		end
	end

	always_comb
	begin
		rdWord = `WORD_ZERO;
		unique case (haddr[11:0])
			`OFS_CTRL:
			begin
				rdWord[`CTRL_EN] = ctrl_q.en;
				rdWord[`CTRL_TEN] = ctrl_q.tenMode;
				rdWord[`CTRL_STRETCH_ENABLE_BIT] = ctrl_q.stretchEn;
				rdWord[`CTRL_REL] = clockRelease_q;
			end
			`OFS_STAT:
			begin
				rdWord[`STAT_RXF] = rxFull_q;
				rdWord[`STAT_TXF] = txFull_q;
				rdWord[`STAT_OVF] = overflow_q;
				rdWord[`STAT_TENM] = tenMatch_q;
				rdWord[`STAT_RDIR] = readDir_q;
			end
			`OFS_ADDR: rdWord[9:0] = ownAddr_q;
			`OFS_TXDATA: rdWord[7:0] = txHold_q;
			`OFS_RXDATA: rdWord[7:0] = rxBuf_q;
			default: rdWord = `WORD_ZERO;
		endcase
	end

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			hrdata_q <= `WORD_ZERO;
		else if (addrPhase && !hwrite)
			hrdata_q <= rdWord;
	end

	// ==========================================================
	// Software settings.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			ctrl_q <= '0;
			ownAddr_q <= `ADDR_RESET;
		end
		else
		begin
			if (wrCtrl)
			begin
				ctrl_q.en <= hwdata[`CTRL_EN];
				ctrl_q.tenMode <= hwdata[`CTRL_TEN];
				ctrl_q.stretchEn <= hwdata[`CTRL_STRETCH_ENABLE_BIT];
			end
			if (wrAddr)
				ownAddr_q <= hwdata[9:0];
		end
	end

	// ==========================================================
	// Link event timing.
	assign active = state_q != i2c_slave_pkg::ST_IDLE;
	assign lastRise = active && link.sclRise && (bitCnt_q == `CNT_LAST_DATA);
	assign ackFall = active && link.sclFall && (bitCnt_q == `CNT_ACK_FALL);
	assign endFall = active && link.sclFall && (bitCnt_q == `CNT_END_FALL);
	assign rxStore = lastRise && (state_q == i2c_slave_pkg::ST_RX) && !rxFull_q;
	assign txAutoClr = endFall && (nextSt_q == i2c_slave_pkg::ST_TX) && !txFull_q;
	assign rxAutoClr = endFall && (state_q == i2c_slave_pkg::ST_RX) && ctrl_q.stretchEn
		&& rxFull_q;
	assign txLoad = txFull_q && ((endFall && (nextSt_q == i2c_slave_pkg::ST_TX))
		|| ((state_q == i2c_slave_pkg::ST_TX) && (bitCnt_q == `CNT_ZERO) && !txLoaded_q));

	// ==========================================================
	// Decision on a completed byte.
	always_comb
	begin
		ackNow = 1'h0;
		evtNow = 1'h0;
		tenSet = 1'h0;
		tenClr = 1'h0;
		nextNow = i2c_slave_pkg::ST_IDLE;
		unique case (state_q)
			i2c_slave_pkg::ST_ADDR:
			begin
				if (!ctrl_q.tenMode)
				begin
					ackNow = match7;
					nextNow = !match7 ? i2c_slave_pkg::ST_IDLE :
						byteIn[0] ? i2c_slave_pkg::ST_TX : i2c_slave_pkg::ST_RX;
				end
				else if (matchHi && !byteIn[0])
				begin
					ackNow = 1'h1;
					tenClr = 1'h1;
					nextNow = i2c_slave_pkg::ST_ADDR2;
				end
				else if (matchHi && tenMatch_q)
				begin
					ackNow = 1'h1;
					nextNow = i2c_slave_pkg::ST_TX;
				end
				else
					tenClr = 1'h1;
				evtNow = ackNow;
			end
			i2c_slave_pkg::ST_ADDR2:
			begin
				ackNow = matchLo;
				evtNow = matchLo;
				tenSet = matchLo;
				tenClr = !matchLo;
				nextNow = matchLo ? i2c_slave_pkg::ST_RX : i2c_slave_pkg::ST_IDLE;
			end
			i2c_slave_pkg::ST_RX:
			begin
				ackNow = !rxFull_q && !overflow_q;
				evtNow = 1'h1;
				nextNow = i2c_slave_pkg::ST_RX;
			end
			i2c_slave_pkg::ST_TX:
			begin
				evtNow = 1'h1;
				nextNow = i2c_slave_pkg::ST_TX;
			end
			default:
			begin
				ackNow = 1'h0;
			end
		endcase
	end

	// ==========================================================
	// Engine state and bit counting.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			state_q <= i2c_slave_pkg::ST_IDLE;
			nextSt_q <= i2c_slave_pkg::ST_IDLE;
			bitCnt_q <= `CNT_ZERO;
			ackPend_q <= 1'h0;
			evtPend_q <= 1'h0;
		end
		else if (!ctrl_q.en || link.stop)
		begin
			state_q <= i2c_slave_pkg::ST_IDLE;
			bitCnt_q <= `CNT_ZERO;
		end
		else if (link.start)
		begin
			state_q <= i2c_slave_pkg::ST_ADDR;
			bitCnt_q <= `CNT_ZERO;
		end
		else if (active)
		begin
			if (link.sclRise)
				bitCnt_q <= bitCnt_q + 4'h1;
			if (lastRise)
			begin
				ackPend_q <= ackNow;
				evtPend_q <= evtNow;
				nextSt_q <= nextNow;
			end
			if (link.sclRise && (bitCnt_q == `CNT_ACK_FALL) && (state_q == i2c_slave_pkg::ST_TX))
				nextSt_q <= link.sdaLevel ? i2c_slave_pkg::ST_IDLE : i2c_slave_pkg::ST_TX;
			if (endFall)
			begin
				state_q <= nextSt_q;
				bitCnt_q <= `CNT_ZERO;
			end
		end
	end

	// ==========================================================
	// Shifting and direction.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			shiftReg_q <= `BYTE_RESET;
			readDir_q <= 1'h0;
		end
		else
		begin
			if (link.sclRise && active && (bitCnt_q < `CNT_ACK_FALL))
				shiftReg_q <= byteIn;
			if (lastRise && (state_q == i2c_slave_pkg::ST_ADDR))
				readDir_q <= byteIn[0];
		end
	end

	// ==========================================================
	// Acknowledge drive and event pulse.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			ackDrive_q <= 1'h0;
			slaveEvent_q <= 1'h0;
		end
		else
		begin
			if (link.start || link.stop || endFall || !ctrl_q.en)
				ackDrive_q <= 1'h0;
			else if (ackFall && ackPend_q)
				ackDrive_q <= 1'h1;
			slaveEvent_q <= endFall && evtPend_q;
		end
	end

	// ==========================================================
	// Transmit shifter.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			txShift_q <= `BYTE_RESET;
			txLoaded_q <= 1'h0;
		end
		else if (txLoad)
		begin
			txShift_q <= txHold_q;
			txLoaded_q <= 1'h1;
		end
		else if (endFall || (state_q != i2c_slave_pkg::ST_TX))
			txLoaded_q <= 1'h0;
		else if (link.sclFall && (bitCnt_q != `CNT_ZERO) && (bitCnt_q < `CNT_ACK_FALL))
			txShift_q <= {txShift_q[6:0], 1'h0};
	end

	// Keeps the last data bit on the line until the following falling edge.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			txLast_q <= 1'h0;
		else if (lastRise && (state_q == i2c_slave_pkg::ST_TX))
			txLast_q <= 1'h1;
		else if (ackFall || link.start || link.stop || (state_q != i2c_slave_pkg::ST_TX))
			txLast_q <= 1'h0;
	end

	// ==========================================================
	// Buffers and flags.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			rxBuf_q <= `BYTE_RESET;
			rxFull_q <= 1'h0;
			overflow_q <= 1'h0;
			txHold_q <= `BYTE_RESET;
			txFull_q <= 1'h0;
			tenMatch_q <= 1'h0;
		end
		else
		begin
			if (rxStore)
				rxBuf_q <= byteIn;
			if (rxStore)
				rxFull_q <= 1'h1;
			else if (rdRx)
				rxFull_q <= 1'h0;
			if (lastRise && (state_q == i2c_slave_pkg::ST_RX) && rxFull_q)
				overflow_q <= 1'h1;
			else if (wrStat && hwdata[`STAT_OVF])
				overflow_q <= 1'h0;
			if (wrTx)
				txHold_q <= hwdata[7:0];
			if (wrTx)
				txFull_q <= 1'h1;
			else if (txLoad)
				txFull_q <= 1'h0;
			if (lastRise && tenSet)
				tenMatch_q <= 1'h1;
			else if (lastRise && tenClr)
				tenMatch_q <= 1'h0;
		end
	end

	// ==========================================================
	// Clock release and stretching.
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			clockRelease_q <= 1'h1;
		else if (swSetRel)
			clockRelease_q <= 1'h1;
		else if (txAutoClr || rxAutoClr)
			clockRelease_q <= 1'h0;
		else if (wrCtrl && ctrl_q.stretchEn)
			clockRelease_q <= 1'h0;
	end

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			holdScl_q <= 1'h0;
		else
			holdScl_q <= !clockRelease_q && (holdScl_q || !link.sclHigh);
	end

	// ==========================================================
	// Pin drive.
	assign sclOut = 1'h0;
	assign sclOe = holdScl_q;
	assign sdaOut = 1'h0;
	assign sdaOe = ackDrive_q || ((state_q == i2c_slave_pkg::ST_TX) && txLoaded_q
		&& ((bitCnt_q < `CNT_ACK_FALL) || txLast_q) && !txShift_q[7]);
	assign slaveEvent = slaveEvent_q;

	// ==========================================================
	// Checks.
	sequence s_stretch;
		!clockRelease_q ##1 (!clockRelease_q && !link.sclHigh) [*1] ##1 sclOe;
	endsequence

	property p_eventOnFall;
		@(posedge clk) disable iff (!rstSync_b)
		slaveEvent |-> $past(link.sclFall) && $past(bitCnt_q) == `CNT_END_FALL;
	endproperty
	a_eventOnFall: assert property (p_eventOnFall) else $error("event off ninth fall");

	property p_rxLoad;
		@(posedge clk) disable iff (!rstSync_b)
		rxStore |=> rxFull_q && rxBuf_q == $past(byteIn);
	endproperty
	a_rxLoad: assert property (p_rxLoad) else $error("receive byte not stored");

	property p_rxFullKeep;
		@(posedge clk) disable iff (!rstSync_b)
		(lastRise && state_q == i2c_slave_pkg::ST_RX && rxFull_q) |=> $stable(rxBuf_q)
			&& overflow_q && !ackPend_q;
	endproperty
	a_rxFullKeep: assert property (p_rxFullKeep) else $error("full buffer overwritten");

	property p_addrKeepsRx;
		@(posedge clk) disable iff (!rstSync_b)
		(state_q == i2c_slave_pkg::ST_ADDR) |=> $stable(rxBuf_q);
	endproperty
	a_addrKeepsRx: assert property (p_addrKeepsRx) else $error("address changed buffer");

	property p_relIgnored;
		@(posedge clk) disable iff (!rstSync_b)
		(!ctrl_q.stretchEn && clockRelease_q && !txAutoClr) |=> clockRelease_q;
	endproperty
	a_relIgnored: assert property (p_relIgnored) else $error("release cleared by write");

	property p_holdNeedsLow;
		@(posedge clk) disable iff (!rstSync_b)
		$rose(sclOe) |-> !$past(link.sclHigh) && !$past(clockRelease_q);
	endproperty
	a_holdNeedsLow: assert property (p_holdNeedsLow) else $error("clock held while high");

	property p_swRelease;
		@(posedge clk) disable iff (!rstSync_b)
		swSetRel |=> clockRelease_q ##1 !sclOe;
	endproperty
	a_swRelease: assert property (p_swRelease) else $error("clock not released");

	property p_txStretch;
		@(posedge clk) disable iff (!rstSync_b)
		(txAutoClr && !swSetRel) ##1 (!link.sclHigh && !swSetRel) |=> sclOe;
	endproperty
	a_txStretch: assert property (p_txStretch) else $error("transmit stretch missing");

	property p_sdaOnLow;
		@(posedge clk) disable iff (!rstSync_b)
		(state_q == i2c_slave_pkg::ST_TX && $changed(sdaOe)) |-> !link.sclHigh;
	endproperty
	a_sdaOnLow: assert property (p_sdaOnLow) else $error("data changed with clock high");

	property p_tenSet;
		@(posedge clk) disable iff (!rstSync_b)
		$rose(tenMatch_q) |-> $past(state_q) == i2c_slave_pkg::ST_ADDR2 ##[0:300] slaveEvent;
	endproperty
	a_tenSet: assert property (p_tenSet) else $error("ten-bit match out of place");

	property p_rxStretch;
		@(posedge clk) disable iff (!rstSync_b)
		(rxAutoClr && !swSetRel) |=> s_stretch or (##[0:2] swSetRel);
	endproperty
	a_rxStretch: assert property (p_rxStretch) else $error("receive stretch missing");

endmodule

/* File: bench/i2c_master_model.sv */
// Purpose: Bus master on the far side of the I2C link.
// Assumes: Both lines have pull-ups; the wire levels come back on scl and sda.
// Notes: A bit takes eight clk cycles; SCL stands still between transfers.
`timescale 1ns/1ps
module i2c_master_model (
	// Clock.
	input wire logic clk,
	// Wire levels.
	input wire logic scl,
	input wire logic sda,
	// Pull-downs.
	output logic sclPull,
	output logic sdaPull
);
	int stalls = 0;
	initial
	begin
		sclPull = 1'b0;
		sdaPull = 1'b0;
	end
	// ==========================================================
	// Bit timing.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Releases SCL and waits while the slave stretches it.
	task automatic sclUp();
		int n;
		n = 0;
		sclPull <= 1'b0;
		tick(1);
		while (scl !== 1'b1 && n < 3000)
		begin
			tick(1);
			n++;
		end
		if (n >= 3000)
			stalls++;
		tick(1);
	endtask
	// Sends nine bits MSB first and samples the wire at each high phase.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			sdaPull <= ~tx[i];
			tick(2);
			sclUp();
			rx[i] = sda;
			tick(2);
			sclPull <= 1'b1;
			tick(2);
		end
		sdaPull <= 1'b0;
	endtask
	task automatic start();
		sclUp();
		tick(2);
		sdaPull <= 1'b1;
		tick(2);
		sclPull <= 1'b1;
		tick(2);
	endtask
	task automatic stop();
		sdaPull <= 1'b1;
		tick(2);
		sclUp();
		tick(2);
		sdaPull <= 1'b0;
		tick(4);
	endtask
endmodule

/* File: bench/i2c_slave_clock_stretch_tb.sv */
// Purpose: Self-checking bench for the I2C slave engine.
// Assumes: One AHB-Lite slave; link lines are pulled up.
// Notes: Expected values follow the register map and link rules.
`timescale 1ns/1ps
`include "i2c_slave_consts.svh"
module i2c_slave_clock_stretch_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = `WORD_ZERO;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = `HSIZE_WORD;
	logic [31:0] hwdata = `WORD_ZERO;
	logic [31:0] hrdata;
	logic hreadyout, hresp, sclOut, sclOe, sdaOut, sdaOe, slaveEvent, mScl, mSda;
	wire sclW = ~(sclOe | mScl);
	wire sdaW = ~(sdaOe | mSda);
	int num_errors = 0;
	int checks = 0;
	int events = 0;
	logic [8:0] rx;
	logic [31:0] rd;
	logic sclPrev = 1'b1;
	logic oePrev = 1'b0;
	always #20 clk = ~clk;
	i2c_slave_clock_stretch DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclIn(sclW), .sclOut(sclOut),
		.sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveEvent(slaveEvent));
	i2c_master_model m (.clk(clk), .scl(sclW), .sda(sdaW), .sclPull(mScl), .sdaPull(mSda));
	// ==========================================================
	// Monitors and checks.
	always @(posedge clk)
		if (slaveEvent === 1'b1)
			events++;
	always @(negedge clk)
	begin
		if (sclPrev && sclW && sdaOe !== oePrev)
			fail("data line moved while clock high");
		sclPrev = sclW;
		oePrev = sdaOe;
	end
	task automatic fail(input string msg);
		num_errors++;
		$display("[ERR] %0t %s", $time, msg);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
			fail($sformatf("got %h expected %h", got, exp));
	endtask
	task automatic finish_test();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Bus and link tasks.
	task automatic waitRdy();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fail("bus hang");
			finish_test();
		end
	endtask
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, a};
		hwrite <= wr;
		htrans <= `HTRANS_NONSEQ;
		waitRdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
		chk({31'h0000_0000, hresp}, `WORD_ZERO);
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, `WORD_ZERO);
		chk(rd, exp);
	endtask
	task automatic byteChk(input logic [8:0] tx, input logic [8:0] exp, input int ev);
		m.xfer(tx, rx);
		repeat (6) @(posedge clk);
		chk({23'h00_0000, rx}, {23'h00_0000, exp});
		chk(events, ev);
	endtask
	// ==========================================================
	// Main sequence.
	initial
	begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rdChk(`OFS_CTRL, 32'h0000_0008);
		rdChk(`OFS_STAT, `WORD_ZERO);
		bus(1'b1, 12'h040, 32'hffff_ffff);
		rdChk(12'h040, `WORD_ZERO);
		bus(1'b1, `OFS_ADDR, 32'h0000_003a);
		bus(1'b1, `OFS_CTRL, 32'h0000_000d);
		m.start();
		byteChk(9'h0e9, 9'h0e8, 1);
		rdChk(`OFS_STAT, `WORD_ZERO);
		byteChk(9'h14b, 9'h14a, 2);
		chk({31'h0000_0000, sclOe}, 32'h0000_0001);
		rdChk(`OFS_RXDATA, 32'h0000_00a5);
		chk({31'h0000_0000, sclOe}, 32'h0000_0001);
		bus(1'b1, `OFS_CTRL, 32'h0000_000d);
		bus(1'b1, `OFS_CTRL, 32'h0000_0009);
		chk({31'h0000_0000, sclOe}, `WORD_ZERO);
		byteChk(9'h0b5, 9'h0b4, 3);
		byteChk(9'h0ef, 9'h0ef, 4);
		rdChk(`OFS_RXDATA, 32'h0000_005a);
		byteChk(9'h0cd, 9'h0cd, 5);
		rdChk(`OFS_RXDATA, 32'h0000_0066);
		rdChk(`OFS_STAT, 32'h0000_0004);
		bus(1'b1, `OFS_STAT, 32'h0000_0004);
		m.stop();
		bus(1'b1, `OFS_CTRL, 32'h0000_0001);
		rdChk(`OFS_CTRL, 32'h0000_0009);
		bus(1'b1, `OFS_CTRL, 32'h0000_000d);
		bus(1'b1, `OFS_CTRL, 32'h0000_0005);
		repeat (8) @(posedge clk);
		chk({31'h0000_0000, sclOe}, `WORD_ZERO);
		bus(1'b1, `OFS_CTRL, 32'h0000_0009);
		m.start();
		byteChk(9'h0eb, 9'h0ea, 6);
		chk({31'h0000_0000, sclOe}, 32'h0000_0001);
		rdChk(`OFS_STAT, 32'h0000_0010);
		fork
			byteChk(9'h1fe, 9'h186, 7);
			begin
				bus(1'b1, `OFS_TXDATA, 32'h0000_00c3);
				bus(1'b1, `OFS_CTRL, 32'h0000_0009);
				bus(1'b1, `OFS_TXDATA, 32'h0000_003c);
			end
		join
		byteChk(9'h1ff, 9'h079, 8);
		chk(m.stalls, `WORD_ZERO);
		m.stop();
		bus(1'b1, `OFS_ADDR, 32'h0000_02c5);
		bus(1'b1, `OFS_CTRL, 32'h0000_000b);
		m.start();
		byteChk(9'h1e9, 9'h1e8, 9);
		rdChk(`OFS_STAT, `WORD_ZERO);
		byteChk(9'h18b, 9'h18a, 10);
		rdChk(`OFS_STAT, 32'h0000_0008);
		byteChk(9'h023, 9'h022, 11);
		rdChk(`OFS_RXDATA, 32'h0000_0011);
		m.stop();
		m.start();
		byteChk(9'h1e5, 9'h1e5, 11);
		rdChk(`OFS_STAT, `WORD_ZERO);
		m.stop();
		m.start();
		byteChk(9'h1e9, 9'h1e8, 12);
		byteChk(9'h189, 9'h189, 12);
		m.stop();
		m.start();
		byteChk(9'h1eb, 9'h1eb, 12);
		m.stop();
		chk({29'h000_0000, hreadyout, sclOut, sdaOut}, 32'h0000_0004);
		finish_test();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		fail("run too long");
		finish_test();
	end
endmodule
